// >>> inc/otc_map.svh
`ifndef OTC_MAP_SVH
`define OTC_MAP_SVH

// Register byte offsets on the AXI4-Lite bus.
`define OTC_OFF_CTRL        8'h00
`define OTC_OFF_LIM_FP      8'h04
`define OTC_OFF_LIM_RR      8'h08
`define OTC_OFF_LIM_RP      8'h0C
`define OTC_OFF_LIM_FR      8'h10
`define OTC_OFF_TERM_FUNC   8'h14
`define OTC_OFF_RELAY_FUNC  8'h18
`define OTC_OFF_STATUS      8'h1C
`define OTC_OFF_MASK        8'h20
`define OTC_OFF_STATE       8'h24

// Control register fields.
`define OTC_CTRL_METHOD_LSB 0
`define OTC_CTRL_WIDTH_LSB  4

// Status and mask bit positions.
`define OTC_EV_OTQ_BIT      0
`define OTC_EV_TRIP_BIT     1

// Reset values.
`define OTC_CTRL_RST        32'h0000_0000
`define OTC_LIM_RST         8'h64
`define OTC_FUNC_RST        6'h00

// Motor control method codes that give a defined over-torque flag.
`define OTC_METHOD_SLV      3'h3
`define OTC_METHOD_SLV0     3'h4
`define OTC_METHOD_VEC      3'h5

// Output terminal function code for the over-torque flag.
`define OTC_FUNC_OTQ        6'h07

// Trip-code width selection.
`define OTC_WIDTH_OFF       2'h0
`define OTC_WIDTH_3BIT      2'h1
`define OTC_WIDTH_4BIT      2'h2

// Highest torque threshold, in percent.
`define OTC_LIM_MAX         8'hC8

// Trip codes.
`define OTC_CODE_NONE       4'h0
`define OTC_CODE_OC         4'h1
`define OTC_CODE_OL         4'h2
`define OTC_CODE_OV         4'h3
`define OTC_CODE_UV         4'h4
`define OTC_CODE_IPF        4'h5
`define OTC_CODE_PWR        4'h6
`define OTC_CODE_BRES       4'h7
`define OTC_CODE_OTHER3     4'h7
`define OTC_CODE_MEM        4'h8
`define OTC_CODE_CT         4'h9
`define OTC_CODE_EXT        4'hA
`define OTC_CODE_GND        4'hB
`define OTC_CODE_SEQ        4'hC
`define OTC_CODE_TEMP       4'hD
`define OTC_CODE_PHASE      4'hE
`define OTC_CODE_USER       4'hF

// AXI response codes.
`define OTC_RESP_OKAY       2'h0
`define OTC_RESP_SLVERR     2'h2

`endif

// >>> inc/otc_pkg.sv
package otc_pkg;

  // Trip causes as reported by the trip detection logic.
  typedef enum logic [4:0] {
    OTC_CAUSE_NONE      = 5'h00,
    OTC_CAUSE_OVERCURR  = 5'h01,
    OTC_CAUSE_OVERLOAD  = 5'h02,
    OTC_CAUSE_LS_OVERLD = 5'h03,
    OTC_CAUSE_OVERVOLT  = 5'h04,
    OTC_CAUSE_UNDERVOLT = 5'h05,
    OTC_CAUSE_PWR_FAIL  = 5'h06,
    OTC_CAUSE_PWR_STAGE = 5'h07,
    OTC_CAUSE_BRAKE_RES = 5'h08,
    OTC_CAUSE_MEM_CPU   = 5'h09,
    OTC_CAUSE_CT        = 5'h0A,
    OTC_CAUSE_EXTERNAL  = 5'h0B,
    OTC_CAUSE_GND_FAULT = 5'h0C,
    OTC_CAUSE_SEQ_PROG  = 5'h0D,
    OTC_CAUSE_TEMP      = 5'h0E,
    OTC_CAUSE_PHASE     = 5'h0F,
    OTC_CAUSE_USER_OPT  = 5'h10
  } otc_cause_t;

  // Operating quadrant of the motor.
  typedef struct packed {
    logic fwd;
    logic regen;
  } otc_quad_t;

  // The four torque thresholds, in percent.
  typedef struct packed {
    logic [7:0] fwd_powering_torque_limit;
    logic [7:0] rev_regen_torque_limit;
    logic [7:0] rev_powering_torque_limit;
    logic [7:0] fwd_regen_torque_limit;
  } otc_limits_t;

  // Trip report from the protection logic.
  typedef struct packed {
    logic       tripped;
    otc_cause_t cause;
  } otc_trip_t;

endpackage : otc_pkg

// >>> verilog/otc_torque_cmp.sv
`timescale 1ns/1ps
`include "otc_map.svh"

module otc_torque_cmp
  import otc_pkg::*;
#(
  parameter int TQ_W = 9
) (
  // Clock and reset.
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_b,
  // Torque and settings.
  input  wire logic [TQ_W-1:0] i_torque,
  input  wire otc_quad_t       i_quad,
  input  wire otc_limits_t     i_limits,
  input  wire logic [2:0]      i_method,
  // Flag.
  output logic                 o_torque_over_flag
);

  logic [7:0] limit;

  always_comb begin
    case ({i_quad.fwd, i_quad.regen})
      2'b10:   limit = i_limits.fwd_powering_torque_limit;
      2'b01:   limit = i_limits.rev_regen_torque_limit;
      2'b00:   limit = i_limits.rev_powering_torque_limit;
      default: limit = i_limits.fwd_regen_torque_limit;
    endcase
  end

  // Under other control methods the flag is held low rather than left floating.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_torque_over_flag <= 1'b0;
    end else if (i_method == `OTC_METHOD_SLV || i_method == `OTC_METHOD_SLV0 ||
                 i_method == `OTC_METHOD_VEC) begin
      o_torque_over_flag <= ({{(TQ_W > 8 ? 0 : 8 - TQ_W){1'b0}}, i_torque} >
                             {{(TQ_W > 8 ? TQ_W - 8 : 0){1'b0}}, limit});
    end else begin
      o_torque_over_flag <= 1'b0;
    end
  end

endmodule : otc_torque_cmp

// >>> verilog/otc_trip_enc.sv
`timescale 1ns/1ps
`include "otc_map.svh"

module otc_trip_enc
  import otc_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  // Trip report and width.
  input  wire otc_trip_t  i_trip,
  input  wire logic [1:0] i_width,
  // Code, bit 0 goes to terminal 11.
  output logic [3:0]      o_code
);

  function automatic logic [3:0] code4(input otc_cause_t c);
    case (c)
      OTC_CAUSE_OVERCURR:  code4 = `OTC_CODE_OC;
      OTC_CAUSE_OVERLOAD:  code4 = `OTC_CODE_OL;
      OTC_CAUSE_LS_OVERLD: code4 = `OTC_CODE_OL;
      OTC_CAUSE_OVERVOLT:  code4 = `OTC_CODE_OV;
      OTC_CAUSE_UNDERVOLT: code4 = `OTC_CODE_UV;
      OTC_CAUSE_PWR_FAIL:  code4 = `OTC_CODE_IPF;
      OTC_CAUSE_PWR_STAGE: code4 = `OTC_CODE_PWR;
      OTC_CAUSE_BRAKE_RES: code4 = `OTC_CODE_BRES;
      OTC_CAUSE_MEM_CPU:   code4 = `OTC_CODE_MEM;
      OTC_CAUSE_CT:        code4 = `OTC_CODE_CT;
      OTC_CAUSE_EXTERNAL:  code4 = `OTC_CODE_EXT;
      OTC_CAUSE_GND_FAULT: code4 = `OTC_CODE_GND;
      OTC_CAUSE_SEQ_PROG:  code4 = `OTC_CODE_SEQ;
      OTC_CAUSE_TEMP:      code4 = `OTC_CODE_TEMP;
      OTC_CAUSE_PHASE:     code4 = `OTC_CODE_PHASE;
      OTC_CAUSE_USER_OPT:  code4 = `OTC_CODE_USER;
      default:             code4 = `OTC_CODE_NONE;
    endcase
  endfunction : code4

  // In 3-bit mode only codes 1 to 6 are dedicated; low-speed overload is not.
  function automatic logic [3:0] code3(input otc_cause_t c);
    case (c)
      OTC_CAUSE_NONE:      code3 = `OTC_CODE_NONE;
      OTC_CAUSE_LS_OVERLD: code3 = `OTC_CODE_OTHER3;
      default:             code3 = (code4(c) <= `OTC_CODE_PWR) ? code4(c)
                                                              : `OTC_CODE_OTHER3;
    endcase
  endfunction : code3

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_code <= `OTC_CODE_NONE;
    end else if (!i_trip.tripped) begin
      o_code <= `OTC_CODE_NONE;
    end else if (i_width == `OTC_WIDTH_4BIT) begin
      o_code <= code4(i_trip.cause);
    end else begin
      o_code <= code3(i_trip.cause);
    end
  end

endmodule : otc_trip_enc

// >>> verilog/otc_top.sv
`timescale 1ns/1ps
`include "otc_map.svh"

module otc_top
  import otc_pkg::*;
#(
  parameter int TQ_W = 9
) (
  // Clock and reset.
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_b,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]      i_awaddr,
  input  wire logic            i_awvalid,
  output logic                 o_awready,
  input  wire logic [31:0]     i_wdata,
  input  wire logic [3:0]      i_wstrb,
  input  wire logic            i_wvalid,
  output logic                 o_wready,
  // AXI4-Lite write response.
  output logic [1:0]           o_bresp,
  output logic                 o_bvalid,
  input  wire logic            i_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]      i_araddr,
  input  wire logic            i_arvalid,
  output logic                 o_arready,
  output logic [31:0]          o_rdata,
  output logic [1:0]           o_rresp,
  output logic                 o_rvalid,
  input  wire logic            i_rready,
  // Drive state.
  input  wire logic [TQ_W-1:0] i_torque,
  input  wire otc_quad_t       i_quad,
  input  wire otc_trip_t       i_trip,
  input  wire logic [5:0]      i_other_func,
  // Output terminals 11 to 15 and the relay.
  output logic [4:0]           o_term,
  output logic                 o_relay,
  output logic                 o_irq
);

  localparam int NTERM = 5;
  localparam logic [31:0] CTRL_RST = `OTC_CTRL_RST;

  // Settings.
  logic [2:0]  method;
  logic [1:0]  width;
  otc_limits_t limits;
  logic [5:0]  term_func [NTERM];
  logic [5:0]  relay_func;
  logic [1:0]  status;
  logic [1:0]  mask;

  // Internal state.
  logic        torque_over_flag;
  logic        torque_over_flag_d;
  logic        tripped_d;
  logic [3:0]  trip_code;
  logic [1:0]  ev_set;
  logic [1:0]  ev_clr;

  // Bus state.
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic [31:0] wr_word;
  logic [31:0] next_rdata;
  logic        rd_hit;

  otc_torque_cmp #(
    .TQ_W               (TQ_W)
  ) u_cmp (
    .i_sys_clk          (i_sys_clk),
    .i_rst_b            (i_rst_b),
    .i_torque           (i_torque),
    .i_quad             (i_quad),
    .i_limits           (limits),
    .i_method           (method),
    .o_torque_over_flag (torque_over_flag)
  );

  otc_trip_enc u_enc (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_trip    (i_trip),
    .i_width   (width),
    .o_code    (trip_code)
  );

  // Decodes a byte offset into a register index; 4'hF marks an unmapped address.
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    case (a)
      `OTC_OFF_CTRL:       reg_index = 4'h0;
      `OTC_OFF_LIM_FP:     reg_index = 4'h1;
      `OTC_OFF_LIM_RR:     reg_index = 4'h2;
      `OTC_OFF_LIM_RP:     reg_index = 4'h3;
      `OTC_OFF_LIM_FR:     reg_index = 4'h4;
      `OTC_OFF_TERM_FUNC:  reg_index = 4'h5;
      `OTC_OFF_RELAY_FUNC: reg_index = 4'h6;
      `OTC_OFF_STATUS:     reg_index = 4'h7;
      `OTC_OFF_MASK:       reg_index = 4'h8;
      `OTC_OFF_STATE:      reg_index = 4'h9;
      default:             reg_index = 4'hF;
    endcase
  endfunction : reg_index

  // Settings above the top of the range are pinned at the top.
  function automatic logic [7:0] clamp_limit(input logic [7:0] v);
    clamp_limit = (v > `OTC_LIM_MAX) ? `OTC_LIM_MAX : v;
  endfunction : clamp_limit

  // Merges the write data into the present word by byte strobe.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Write address and data are taken independently; the write happens once both are in.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      aw_held   <= 1'b0;
      aw_addr   <= 8'h00;
      o_awready <= 1'b1;
    end else if (i_awvalid && o_awready) begin
      aw_held   <= 1'b1;
      aw_addr   <= {i_awaddr[7:2], 2'b00};
      o_awready <= 1'b0;
    end else if (do_write) begin
      aw_held   <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      w_held   <= 1'b0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      o_wready <= 1'b1;
    end else if (i_wvalid && o_wready) begin
      w_held   <= 1'b1;
      w_data   <= i_wdata;
      w_strb   <= i_wstrb;
      o_wready <= 1'b0;
    end else if (do_write) begin
      w_held   <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      o_wready <= 1'b1;
    end
  end

  assign do_write = aw_held && w_held && !o_bvalid;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_bvalid <= 1'b0;
      o_bresp  <= `OTC_RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp  <= (reg_index(aw_addr) == 4'hF || reg_index(aw_addr) == 4'h9) ?
                  `OTC_RESP_SLVERR : `OTC_RESP_OKAY;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_comb begin
    wr_word = 32'h0000_0000;
    case (reg_index(aw_addr))
      4'h0:    wr_word = {24'h00_0000, 2'b00, width, 1'b0, method};
      4'h1:    wr_word = {24'h00_0000, limits.fwd_powering_torque_limit};
      4'h2:    wr_word = {24'h00_0000, limits.rev_regen_torque_limit};
      4'h3:    wr_word = {24'h00_0000, limits.rev_powering_torque_limit};
      4'h4:    wr_word = {24'h00_0000, limits.fwd_regen_torque_limit};
      4'h6:    wr_word = {26'h000_0000, relay_func};
      4'h8:    wr_word = {30'h0000_0000, mask};
      default: wr_word = 32'h0000_0000;
    endcase
    wr_word = merge(wr_word, w_data, w_strb);
  end

  // Writes to a width code of 03 leave the terminals unforced, as with 00.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      method <= CTRL_RST[`OTC_CTRL_METHOD_LSB +: 3];
      width  <= CTRL_RST[`OTC_CTRL_WIDTH_LSB +: 2];
    end else if (do_write && reg_index(aw_addr) == 4'h0) begin
      method <= wr_word[`OTC_CTRL_METHOD_LSB +: 3];
      width  <= wr_word[`OTC_CTRL_WIDTH_LSB +: 2];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      limits <= {4{`OTC_LIM_RST}};
    end else if (do_write) begin
      case (reg_index(aw_addr))
        4'h1:    limits.fwd_powering_torque_limit <= clamp_limit(wr_word[7:0]);
        4'h2:    limits.rev_regen_torque_limit    <= clamp_limit(wr_word[7:0]);
        4'h3:    limits.rev_powering_torque_limit <= clamp_limit(wr_word[7:0]);
        4'h4:    limits.fwd_regen_torque_limit    <= clamp_limit(wr_word[7:0]);
        default: limits <= limits;
      endcase
    end
  end

  // Terminal function selections: six bits per terminal, terminal 11 lowest.
  genvar gt;
  generate
    for (gt = 0; gt < NTERM; gt++) begin : g_func
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          term_func[gt] <= `OTC_FUNC_RST;
        end else if (do_write && reg_index(aw_addr) == 4'h5 && w_strb != 4'h0) begin
          term_func[gt] <= w_data[6*gt +: 6];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      relay_func <= `OTC_FUNC_RST;
      mask       <= 2'b00;
    end else if (do_write && reg_index(aw_addr) == 4'h6) begin
      relay_func <= wr_word[5:0];
    end else if (do_write && reg_index(aw_addr) == 4'h8) begin
      mask       <= wr_word[1:0];
    end
  end

  // Events: a rising over-torque flag and entry into the tripped state.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      torque_over_flag_d <= 1'b0;
      tripped_d          <= 1'b0;
    end else begin
      torque_over_flag_d <= torque_over_flag;
      tripped_d          <= i_trip.tripped;
    end
  end

  assign ev_set[`OTC_EV_OTQ_BIT]  = torque_over_flag && !torque_over_flag_d;
  assign ev_set[`OTC_EV_TRIP_BIT] = i_trip.tripped && !tripped_d;
  assign ev_clr = (do_write && reg_index(aw_addr) == 4'h7) ? (w_data[1:0] & {2{w_strb[0]}})
                                                           : 2'b00;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      status <= 2'b00;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & mask);
    end
  end

  // Read channel: one read in flight; arready drops until the data is taken.
  always_comb begin
    rd_hit     = 1'b1;
    next_rdata = 32'h0000_0000;
    case (reg_index(i_araddr))
      4'h0: next_rdata = {24'h00_0000, 2'b00, width, 1'b0, method};
      4'h1: next_rdata = {24'h00_0000, limits.fwd_powering_torque_limit};
      4'h2: next_rdata = {24'h00_0000, limits.rev_regen_torque_limit};
      4'h3: next_rdata = {24'h00_0000, limits.rev_powering_torque_limit};
      4'h4: next_rdata = {24'h00_0000, limits.fwd_regen_torque_limit};
      4'h5: next_rdata = {2'b00, term_func[4], term_func[3], term_func[2],
                          term_func[1], term_func[0]};
      4'h6: next_rdata = {26'h000_0000, relay_func};
      4'h7: next_rdata = {30'h0000_0000, status};
      4'h8: next_rdata = {30'h0000_0000, mask};
      4'h9: next_rdata = {18'h0_0000, o_relay, o_term, torque_over_flag,
                          i_trip.tripped, 2'b00, trip_code};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `OTC_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= next_rdata;
      o_rresp   <= rd_hit ? `OTC_RESP_OKAY : `OTC_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
    end
  end

  // Terminal drive: trip code first, then function 07, else the other function.
  generate
    for (gt = 0; gt < NTERM; gt++) begin : g_term
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          o_term[gt] <= 1'b0;
        end else if (width == `OTC_WIDTH_3BIT && gt < 3) begin
          o_term[gt] <= trip_code[gt];
        end else if (width == `OTC_WIDTH_4BIT && gt < 4) begin
          o_term[gt] <= trip_code[gt];
        end else if (term_func[gt] == `OTC_FUNC_OTQ) begin
          o_term[gt] <= torque_over_flag;
        end else begin
          o_term[gt] <= i_other_func[gt];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_relay <= 1'b0;
    end else if (relay_func == `OTC_FUNC_OTQ) begin
      o_relay <= torque_over_flag;
    end else begin
      o_relay <= i_other_func[5];
    end
  end

endmodule : otc_top

// >>> test/otc_term_reader.sv
`timescale 1ns/1ps

module otc_term_reader (
  // Clock.
  input  wire logic       i_sys_clk,
  // Terminals as wired to the controller.
  input  wire logic [4:0] i_term,
  input  wire logic       i_relay,
  // What the controller has latched.
  output logic [4:0]      o_seen,
  output logic            o_brake_end
);
  // The controller only samples on its own edge, so it lags the drive by one cycle.
  always_ff @(posedge i_sys_clk) begin
    o_seen      <= i_term;
    o_brake_end <= i_relay;
  end
endmodule : otc_term_reader

// >>> test/otc_top_chk.sv
`timescale 1ns/1ps
`include "otc_map.svh"

module otc_top_chk (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // Bus handshakes.
  input  wire logic        i_awvalid,
  input  wire logic        o_awready,
  input  wire logic        i_wvalid,
  input  wire logic        o_wready,
  input  wire logic [1:0]  o_bresp,
  input  wire logic        o_bvalid,
  input  wire logic        i_bready,
  input  wire logic        i_arvalid,
  input  wire logic        o_arready,
  input  wire logic [31:0] o_rdata,
  input  wire logic [1:0]  o_rresp,
  input  wire logic        o_rvalid,
  input  wire logic        i_rready,
  // Terminals.
  input  wire logic [4:0]  o_term,
  input  wire logic        o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  wr_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read response missing");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  aw_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted too early");
  ar_block_a: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted too early");
  err_zero_a: assert property (o_rvalid && o_rresp == `OTC_RESP_SLVERR |-> o_rdata == 32'h0)
    else $error("error read carries data");
  b_release_a: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready)
    else $error("write response not released");
  reset_quiet_a: assert property (disable iff (1'b0) !i_rst_b |=> o_term == 5'h00 && !o_irq)
    else $error("outputs active in reset");
endmodule : otc_top_chk

bind otc_top otc_top_chk otc_top_chk_inst (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .o_term(o_term), .o_irq(o_irq));

// >>> test/overtorque_and_trip_code_output_bench.sv
`timescale 1ns/1ps
`include "otc_map.svh"

module overtorque_and_trip_code_output_bench
  import otc_pkg::*;
;
  logic        clk = 0, rst_b = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0]  wstrb = 0;
  logic [8:0]  torque = 0;
  otc_quad_t   quad = '0;
  otc_trip_t   trip = '0;
  logic [5:0]  other = 0;
  logic        awready, wready, bvalid, arready, rvalid, relay, irq, brake_end;
  logic [1:0]  bresp, rresp, r;
  logic [4:0]  term, seen;
  logic [7:0]  lim;
  int          mismatches = 0, n_compared = 0;
  // Threshold register per quadrant, indexed by {fwd,regen}.
  logic [7:0]  lim_addr [4] = '{`OTC_OFF_LIM_RP, `OTC_OFF_LIM_RR, `OTC_OFF_LIM_FP, `OTC_OFF_LIM_FR};
  logic [3:0]  code4 [17] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                              4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};

  always #50 clk = ~clk;

  otc_top #(.TQ_W(9)) otc_top_inst (.i_sys_clk(clk), .i_rst_b(rst_b), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_torque(torque), .i_quad(quad), .i_trip(trip), .i_other_func(other),
    .o_term(term), .o_relay(relay), .o_irq(irq));

  otc_term_reader otc_term_reader_inst (.i_sys_clk(clk), .i_term(term), .i_relay(relay),
    .o_seen(seen), .o_brake_end(brake_end));

  function automatic logic exp_flag(logic [8:0] t, logic [7:0] l, int m);
    return (m >= 3 && m <= 5) && (t > {1'b0, l});
  endfunction : exp_flag

  function automatic logic [3:0] exp_code(int c, int w);
    if (w == 2) return code4[c];
    // The narrow code keeps causes 1 to 7 except low-speed overload; every other trip cause folds into seven.
    if (c == 0) return 4'h0;
    if (c <= 7 && c != 3) return code4[c];
    return 4'h7;
  endfunction : exp_code

  task automatic check(string name, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a; wdata <= v; wstrb <= 4'hF;
    awvalid <= 1; wvalid <= 1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1;
    end
    resp = bresp;
    bready <= 0;
  endtask : wr

  task automatic rd(logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a; arvalid <= 1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1;
    end
    v = rdata;
    resp = rresp;
    rready <= 0;
  endtask : rd

  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    #(20000 * 100);
    mismatches++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h7266B5AB));
    repeat (8) @(posedge clk);
    rst_b <= 1;
    rd(`OTC_OFF_CTRL, d, r); check("ctrl", d, 32'h0);
    for (int i = 1; i <= 4; i++) begin
      rd(8'(4 * i), d, r); check("limit reset", d, 32'h64);
    end
    rd(8'h28, d, r); check("unmapped resp", r, `OTC_RESP_SLVERR);
    wr(`OTC_OFF_STATE, 32'h1, r); check("ro resp", r, `OTC_RESP_SLVERR);
    wr(`OTC_OFF_LIM_FP, 32'hFF, r); rd(`OTC_OFF_LIM_FP, d, r);
    check("limit clamp", d, 32'hC8);
    $display("register test done");
    wr(`OTC_OFF_CTRL, 32'h3, r);
    wr(`OTC_OFF_TERM_FUNC, 32'h7, r);
    wr(`OTC_OFF_RELAY_FUNC, 32'h7, r);
    for (int q = 0; q < 4; q++) begin
      for (int i = 1; i <= 4; i++) wr(8'(4 * i), 32'hC8, r);
      lim = 8'($urandom_range(199, 1));
      wr(lim_addr[q], {24'h0, lim}, r);
      for (int k = 0; k < 3; k++) begin
        @(posedge clk);
        quad <= otc_quad_t'(2'(q)); torque <= {1'b0, lim} + 9'(k) - 9'h1;
        other <= 6'($urandom());
        repeat (4) @(posedge clk);
        check("term flag", term[0], exp_flag(torque, lim, 3));
        check("relay flag", relay, exp_flag(torque, lim, 3));
        check("reader flag", seen[0], exp_flag(torque, lim, 3));
        check("brake end", brake_end, exp_flag(torque, lim, 3));
      end
    end
    for (int m = 0; m < 8; m++) begin
      wr(`OTC_OFF_CTRL, 32'(m), r);
      torque <= 9'h0C9;
      repeat (4) @(posedge clk);
      check("method flag", term[0], exp_flag(torque, 8'hC8, m));
    end
    $display("torque test done");
    wr(`OTC_OFF_TERM_FUNC, 32'h0, r);
    wr(`OTC_OFF_RELAY_FUNC, 32'h0, r);
    torque <= 9'h0;
    for (int w = 1; w <= 2; w++) begin
      wr(`OTC_OFF_CTRL, 32'(w << 4), r);
      for (int c = 0; c < 17; c++) begin
        @(posedge clk);
        trip <= '{tripped: c != 0, cause: otc_cause_t'(c)};
        other <= 6'($urandom());
        repeat (4) @(posedge clk);
        if (w == 2) check("code4", term[3:0], exp_code(c, w));
        else check("code3", term[3:0], {other[3], 3'(exp_code(c, w))});
      end
    end
    $display("trip code test done");
    trip <= '0;
    wr(`OTC_OFF_STATUS, 32'h3, r);
    wr(`OTC_OFF_MASK, 32'h0, r);
    trip <= '{tripped: 1'b1, cause: OTC_CAUSE_GND_FAULT};
    repeat (4) @(posedge clk);
    check("masked irq", irq, 1'b0);
    rd(`OTC_OFF_STATUS, d, r); check("status", d, 32'h2);
    wr(`OTC_OFF_MASK, 32'h2, r);
    repeat (3) @(posedge clk);
    check("irq", irq, 1'b1);
    wr(`OTC_OFF_STATUS, 32'h2, r);
    repeat (3) @(posedge clk);
    check("cleared irq", irq, 1'b0);
    wr(`OTC_OFF_CTRL, 32'h0, r);
    repeat (3) @(posedge clk);
    check("width off", term[3:0], other[3:0]);
    $display("interrupt test done");
    give_verdict();
  end
endmodule : overtorque_and_trip_code_output_bench
